/* include/dpll_pkg.sv */
// Constants and types of the mode state controller
// Behaviour
// - Mode pins: 00 normal, 01 holdover, 10 freerun
// - State changes only at frame pulse rise
// - Normal falls to auto-holdover on bad reference
// - Auto-holdover returns to normal when reference good
// - Mode pins ignored between normal and auto-holdover
// - A state change disables phase-error correction, except from either holdover into normal
// - Entering normal from holdover follows correction pin
// - Outputs lock to reference within 30 seconds
// - Normal indicator high in normal state
// - Fast-lock request speeds locking in normal
// - Bus clocks 32.768 down to 2.048 MHz
// - T1 and DS2 clocks 3.088, 1.544, 6.312 MHz
// - 31 ns active-low frame pulse
// - 61 ns active-low frame pulse
// - 122 ns active-high pulse, sampling event
// - 244 ns active-low frame pulse
// - Receive and transmit 488 ns sync pulses
// - Normal outputs synchronous to the reference
// - Holdover indicator high in either holdover
// - Freerun indicator high in freerun state
// - Reset holds all clocks and pulses high
// - Correction pin high enables, sampled at frame
package dpll_pkg;
   localparam int CLK_KHZ = 250000;
   localparam int FRAME_US = 125;
   localparam int FRAME_CYCLES = FRAME_US * CLK_KHZ / 1000;
   localparam logic [14:0] FRAME_LAST = 15'(FRAME_CYCLES - 1);
   localparam logic signed [15:0] FRAME_LEN = 16'(FRAME_CYCLES);
   localparam logic [14:0] FRAME_HALF = 15'(FRAME_CYCLES / 2);
   // Least pulse widths in ns, rounded up to cycles
   localparam int FP31_NS = 31;
   localparam int FP61_NS = 61;
   localparam int FP122_NS = 122;
   localparam int FP244_NS = 244;
   localparam int SYNC_NS = 488;
   localparam logic [14:0] FP31_CYC = 15'((FP31_NS * CLK_KHZ + 999999) / 1000000);
   localparam logic [14:0] FP61_CYC = 15'((FP61_NS * CLK_KHZ + 999999) / 1000000);
   localparam logic [14:0] FP122_CYC = 15'((FP122_NS * CLK_KHZ + 999999) / 1000000);
   localparam logic [14:0] FP244_CYC = 15'((FP244_NS * CLK_KHZ + 999999) / 1000000);
   localparam logic [14:0] SYNC_CYC = 15'((SYNC_NS * CLK_KHZ + 999999) / 1000000);
   // Phase slew per frame and lock tolerance, in cycles
   localparam logic signed [15:0] SLOW_SLEW = 16'sh0001;
   localparam logic signed [15:0] FAST_SLEW = 16'sh0040;
   localparam logic signed [15:0] LOCK_TOL = 16'sh0002;
   // Output clock generators: 32.768 16.384 8.192 4.096 2.048 3.088 1.544 6.312
   localparam int NCO_COUNT = 8;
   localparam int NCO_W = 32;
   localparam int NCO_MSB = NCO_W - 1;
   localparam int NCO_KHZ [NCO_COUNT] = '{32768, 16384, 8192, 4096, 2048, 3088, 1544, 6312};
   typedef logic [NCO_COUNT-1:0][NCO_W-1:0] nco_word_t;
   function automatic logic [NCO_W-1:0] nco_inc(input int khz);
      nco_inc = NCO_W'((64'(khz) << NCO_W) / 64'(CLK_KHZ));
   endfunction
   // Mode pin codes
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_HOLD = 2'h1;
   localparam logic [1:0] MODE_FREE = 2'h2;
   typedef enum logic [1:0] {
      ST_NORMAL = 2'h0,
      ST_AUTO_HOLD = 2'h1,
      ST_HOLDOVER = 2'h3,
      ST_FREERUN = 2'h2
   } dpll_state_t;
   // Reference monitor
   localparam logic [1:0] FSEL_8K = 2'h1;
   localparam logic [1:0] FSEL_1M544 = 2'h2;
   localparam logic [1:0] FSEL_2M048 = 2'h3;
   localparam int REF_8K_KHZ = 8;
   localparam int REF_1M544_KHZ = 1544;
   localparam int REF_2M048_KHZ = 2048;
   localparam logic [15:0] PER_8K = 16'(CLK_KHZ / REF_8K_KHZ);
   localparam logic [15:0] PER_1M544 = 16'(CLK_KHZ / REF_1M544_KHZ);
   localparam logic [15:0] PER_2M048 = 16'(CLK_KHZ / REF_2M048_KHZ);
   localparam logic [8:0] DIV_8K = 9'h000;
   localparam logic [8:0] DIV_1M544 = 9'h0C0;
   localparam logic [8:0] DIV_2M048 = 9'h0FF;
   localparam logic [2:0] REF_GOOD_RUN = 3'h4;
   // Register map, byte offsets
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_PHASE = 4'h4;
   localparam logic [3:0] REG_CTRL = 4'h8;
   localparam int CTRL_FAST = 0;
   localparam int CTRL_TIE_CLR = 1;
endpackage

/* include/ref_mon_if.sv */
// Carrier from the reference monitor to the state controller
`timescale 1ns/1ps
interface ref_mon_if;
   logic ref_valid;
   logic epoch;
   modport mon (output ref_valid, output epoch);
   modport ctl (input ref_valid, input epoch);
endinterface

/* rtl/dpll_mode_state_control.sv */
// Mode state controller and timing output generator
`timescale 1ns/1ps
module dpll_mode_state_control (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_ref,
   input wire logic [1:0] i_freq_select,
   input wire logic i_mode_select_hi,
   input wire logic i_mode_select_lo,
   input wire logic i_phase_error_corr_enable,
   input wire logic i_fast_lock_request,
   input wire logic i_tie_clear_n,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   output logic o_clk_32m768_out,
   output logic o_clk_16m384_out,
   output logic o_clk_8m192_out,
   output logic o_clk_4m096_out,
   output logic o_clk_2m048_out,
   output logic o_clk_3m088_out,
   output logic o_clk_1m544_out,
   output logic o_clk_6m312_out,
   output logic o_frame_pulse_31ns_n,
   output logic o_frame_pulse_61ns_n,
   output logic o_frame_pulse_122ns,
   output logic o_frame_pulse_244ns_n,
   output logic o_receive_sync_pulse,
   output logic o_transmit_sync_pulse,
   output logic o_normal,
   output logic o_holdover,
   output logic o_freerun,
   output logic o_lock
);
   import dpll_pkg::*;

   // Pin order in the synchroniser
   localparam int P_SEL_HI = 4;
   localparam int P_SEL_LO = 3;
   localparam int P_TIE = 2;
   localparam int P_FAST_LOCK_REQUEST = 1;
   localparam int P_TCLR_N = 0;

   typedef struct packed {
      logic [4:0] q1, q2, q3, pin;
      dpll_state_t state;
      logic tie_on;
      logic tie_capture;
      logic signed [15:0] tie_offset;
      logic signed [15:0] err;
      logic err_pending;
      logic [14:0] cnt;
      logic [14:0] frame_end;
      nco_word_t acc;
      logic [NCO_COUNT-1:0] clk;
      logic fp31_n, fp61_n, fp122, fp244_n, rsp, transmit_sync_pulse;
      logic st_normal, st_hold, st_free, lock;
      logic ctrl_fast;
      logic bus_wait;
      logic [31:0] rdata;
   } core_state_t;

   core_state_t s, next_s;
   ref_mon_if mon_if ();
   nco_word_t acc_step;
   logic frame_wrap;
   logic [1:0] mode;
   logic [14:0] next_cnt;
   logic signed [15:0] meas, corr, adj, step;
   logic to_normal, changed;
   logic bus_req, bus_accept;
   logic [31:0] rd_value;

   // ----------------------------------------------
   // Reference monitor
   // ----------------------------------------------
   ref_validity_monitor u_mon (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_ref(i_ref),
      .i_freq_select(i_freq_select),
      .mon(mon_if.mon)
   );

   // ----------------------------------------------
   // Output clock generators
   // ----------------------------------------------
   assign frame_wrap = (s.cnt == s.frame_end);
   genvar g;
   generate
      for (g = 0; g < NCO_COUNT; g++) begin : g_nco
         // Restart at each frame boundary keeps every clock frame aligned
         assign acc_step[g] = frame_wrap ? '0 : s.acc[g] + nco_inc(NCO_KHZ[g]);
      end
   endgenerate

   // ----------------------------------------------
   // Next state
   // ----------------------------------------------
   always_comb begin
      next_s = s;
      mode = {s.pin[P_SEL_HI], s.pin[P_SEL_LO]};
      meas = '0;
      corr = '0;
      adj = '0;
      step = SLOW_SLEW;
      to_normal = 1'b0;
      changed = 1'b0;
      rd_value = '0;
      // Three-stage synchroniser, level taken when stages two and three agree
      next_s.q1 = {i_mode_select_hi, i_mode_select_lo, i_phase_error_corr_enable,
                   i_fast_lock_request, i_tie_clear_n};
      next_s.q2 = s.q1;
      next_s.q3 = s.q2;
      next_s.pin = (~(s.q2 ^ s.q3) & s.q3) | ((s.q2 ^ s.q3) & s.pin);

      // Shared frame counter
      next_cnt = frame_wrap ? '0 : s.cnt + 15'h0001;
      next_s.cnt = next_cnt;
      next_s.acc = acc_step;
      for (int i = 0; i < NCO_COUNT; i++) begin
         next_s.clk[i] = ~acc_step[i][NCO_MSB];
      end
      next_s.fp31_n = ~(next_cnt < FP31_CYC);
      next_s.fp61_n = ~(next_cnt < FP61_CYC);
      next_s.fp122 = (next_cnt < FP122_CYC);
      next_s.fp244_n = ~(next_cnt < FP244_CYC);
      next_s.rsp = (next_cnt < SYNC_CYC);
      next_s.transmit_sync_pulse = (next_cnt < SYNC_CYC);

      // Phase of the reference epoch against the frame start
      if (s.cnt < FRAME_HALF) begin
         meas = 16'(s.cnt);
      end else begin
         meas = 16'(s.cnt) - FRAME_LEN;
      end
      if (mon_if.epoch) begin
         next_s.err = meas;
         next_s.err_pending = 1'b1;
         if (s.tie_capture) begin
            next_s.tie_offset = meas;
            next_s.tie_capture = 1'b0;
         end
         corr = s.tie_on && !s.tie_capture ? meas - s.tie_offset : meas;
         next_s.lock = (s.state == ST_NORMAL) && (corr <= LOCK_TOL) && (corr >= -LOCK_TOL);
      end
      if (!s.pin[P_TCLR_N]) begin
         next_s.tie_offset = '0;
      end

      // ----------------------------------------------
      // Mode state machine, evaluated at the frame boundary
      // ----------------------------------------------
      if (frame_wrap) begin
         unique case (s.state)
            ST_NORMAL: begin
               if (mode == MODE_HOLD) begin
                  next_s.state = ST_HOLDOVER;
               end else if (mode == MODE_FREE) begin
                  next_s.state = ST_FREERUN;
               end else if (!mon_if.ref_valid) begin
                  next_s.state = ST_AUTO_HOLD;
               end
            end
            ST_AUTO_HOLD: begin
               if (mode == MODE_HOLD) begin
                  next_s.state = ST_HOLDOVER;
               end else if (mode == MODE_FREE) begin
                  next_s.state = ST_FREERUN;
               end else if (mon_if.ref_valid) begin
                  next_s.state = ST_NORMAL;
               end
            end
            ST_HOLDOVER, ST_FREERUN: begin
               if (mode == MODE_NORMAL) begin
                  next_s.state = ST_NORMAL;
               end else if (mode == MODE_HOLD) begin
                  next_s.state = ST_HOLDOVER;
               end else if (mode == MODE_FREE) begin
                  next_s.state = ST_FREERUN;
               end
            end
         endcase
         changed = (next_s.state != s.state);
         to_normal = changed && (next_s.state == ST_NORMAL) && (s.state != ST_FREERUN);
         if (to_normal) begin
            next_s.tie_on = s.pin[P_TIE];
            next_s.tie_capture = s.pin[P_TIE];
         end else if (changed) begin
            next_s.tie_on = 1'b0;
            next_s.tie_capture = 1'b0;
         end else begin
            next_s.tie_on = s.pin[P_TIE];
         end
         if (next_s.state != ST_NORMAL) begin
            next_s.lock = 1'b0;
         end

         // Slew limited frame length correction in normal state
         next_s.frame_end = FRAME_LAST;
         if (s.state == ST_NORMAL && next_s.state == ST_NORMAL
               && s.err_pending) begin
            corr = s.tie_on ? s.err - s.tie_offset : s.err;
            if (s.pin[P_FAST_LOCK_REQUEST] || s.ctrl_fast) begin
               step = FAST_SLEW;
            end
            if (corr > step) begin
               adj = step;
            end else if (corr < -step) begin
               adj = -step;
            end else begin
               adj = corr;
            end
            next_s.frame_end = 15'(16'(FRAME_LAST) + adj);
            // An epoch in the same cycle keeps its sample pending
            next_s.err_pending = mon_if.epoch;
         end
      end

      next_s.st_normal = (next_s.state == ST_NORMAL);
      next_s.st_hold = (next_s.state == ST_HOLDOVER) || (next_s.state == ST_AUTO_HOLD);
      next_s.st_free = (next_s.state == ST_FREERUN);

      // ----------------------------------------------
      // Avalon-MM slave, one wait cycle per access
      // ----------------------------------------------
      unique case (i_avs_address)
         REG_STATUS: begin
            rd_value = {25'h0000000, mode, s.tie_on, mon_if.ref_valid, s.lock, s.state};
         end
         REG_PHASE: begin
            rd_value = {{16{s.err[15]}}, s.err};
         end
         REG_CTRL: begin
            rd_value = {31'h00000000, s.ctrl_fast};
         end
         default: rd_value = '0;
      endcase
      bus_req = i_avs_read | i_avs_write;
      bus_accept = bus_req & ~s.bus_wait;
      next_s.bus_wait = ~(bus_req & s.bus_wait);
      if (i_avs_read && s.bus_wait) begin
         next_s.rdata = rd_value;
      end
      if (i_avs_write && bus_accept && i_avs_address == REG_CTRL && i_avs_byteenable[0]) begin
         next_s.ctrl_fast = i_avs_writedata[CTRL_FAST];
         if (i_avs_writedata[CTRL_TIE_CLR]) begin
            next_s.tie_offset = '0;
         end
      end

      if (i_rst) begin
         next_s = '0;
         next_s.state = ST_FREERUN;
         next_s.frame_end = FRAME_LAST;
         next_s.clk = '1;
         next_s.fp31_n = 1'b1;
         next_s.fp61_n = 1'b1;
         next_s.fp122 = 1'b1;
         next_s.fp244_n = 1'b1;
         next_s.rsp = 1'b1;
         next_s.transmit_sync_pulse = 1'b1;
         next_s.st_free = 1'b1;
         next_s.bus_wait = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      s <= next_s;
   end

   // ----------------------------------------------
   // Outputs
   // ----------------------------------------------
   assign o_avs_readdata = s.rdata;
   assign o_avs_waitrequest = s.bus_wait;
   assign o_clk_32m768_out = s.clk[0];
   assign o_clk_16m384_out = s.clk[1];
   assign o_clk_8m192_out = s.clk[2];
   assign o_clk_4m096_out = s.clk[3];
   assign o_clk_2m048_out = s.clk[4];
   assign o_clk_3m088_out = s.clk[5];
   assign o_clk_1m544_out = s.clk[6];
   assign o_clk_6m312_out = s.clk[7];
   assign o_frame_pulse_31ns_n = s.fp31_n;
   assign o_frame_pulse_61ns_n = s.fp61_n;
   assign o_frame_pulse_122ns = s.fp122;
   assign o_frame_pulse_244ns_n = s.fp244_n;
   assign o_receive_sync_pulse = s.rsp;
   assign o_transmit_sync_pulse = s.transmit_sync_pulse;
   assign o_normal = s.st_normal;
   assign o_holdover = s.st_hold;
   assign o_freerun = s.st_free;
   assign o_lock = s.lock;
endmodule

/* rtl/ref_validity_monitor.sv */
// Reference input period checker and epoch marker
`timescale 1ns/1ps
module ref_validity_monitor (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_ref,
   input wire logic [1:0] i_freq_select,
   ref_mon_if.mon mon
);
   import dpll_pkg::*;

   typedef struct packed {
      logic q1, q2, q3, lvl, lvl_d;
      logic [1:0] sel;
      logic [15:0] period;
      logic [2:0] run;
      logic [8:0] div;
      logic valid;
      logic epoch;
   } mon_state_t;

   mon_state_t s, next_s;
   logic [15:0] per_nom, per_min, per_max;
   logic [8:0] div_last;
   logic sel_ok, fall;

   always_comb begin
      next_s = s;
      per_nom = PER_2M048;
      div_last = DIV_2M048;
      sel_ok = 1'b1;
      unique case (s.sel)
         FSEL_8K: begin
            per_nom = PER_8K;
            div_last = DIV_8K;
         end
         FSEL_1M544: begin
            per_nom = PER_1M544;
            div_last = DIV_1M544;
         end
         FSEL_2M048: begin
         end
         default: sel_ok = 1'b0;
      endcase
      // Capture window of plus or minus one sixteenth
      per_min = per_nom - (per_nom >> 4);
      per_max = per_nom + (per_nom >> 4);
      next_s.q1 = i_ref;
      next_s.q2 = s.q1;
      next_s.q3 = s.q2;
      if (s.q2 == s.q3) begin
         next_s.lvl = s.q3;
      end
      next_s.lvl_d = s.lvl;
      next_s.epoch = 1'b0;
      fall = s.lvl_d & ~s.lvl;
      if (fall) begin
         next_s.period = '0;
         if (sel_ok && s.period >= per_min && s.period <= per_max) begin
            if (s.run != REF_GOOD_RUN) begin
               next_s.run = s.run + 3'h1;
            end
            next_s.valid = (next_s.run == REF_GOOD_RUN);
            if (s.div == div_last) begin
               next_s.div = '0;
               next_s.epoch = next_s.valid;
            end else begin
               next_s.div = s.div + 9'h001;
            end
         end else begin
            next_s.run = '0;
            next_s.valid = 1'b0;
            next_s.div = '0;
         end
      end else if (s.period > per_max) begin
         next_s.run = '0;
         next_s.valid = 1'b0;
         next_s.div = '0;
      end else begin
         next_s.period = s.period + 16'h0001;
      end
      if (i_rst) begin
         next_s = '0;
         next_s.sel = i_freq_select;
      end
   end

   always_ff @(posedge i_core_clk) begin
      s <= next_s;
   end

   assign mon.ref_valid = s.valid;
   assign mon.epoch = s.epoch;
endmodule

/* tb/dpll_mode_assertions.sv */
// Port-level checks on the mode state controller
`timescale 1ns/1ps
module dpll_mode_assertions (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic o_clk_32m768_out,
   input wire logic o_clk_16m384_out,
   input wire logic o_clk_8m192_out,
   input wire logic o_clk_4m096_out,
   input wire logic o_clk_2m048_out,
   input wire logic o_clk_3m088_out,
   input wire logic o_clk_1m544_out,
   input wire logic o_clk_6m312_out,
   input wire logic o_frame_pulse_31ns_n,
   input wire logic o_frame_pulse_61ns_n,
   input wire logic o_frame_pulse_122ns,
   input wire logic o_frame_pulse_244ns_n,
   input wire logic o_receive_sync_pulse,
   input wire logic o_transmit_sync_pulse,
   input wire logic o_normal,
   input wire logic o_holdover,
   input wire logic o_freerun
);
   import dpll_pkg::*;
   logic fp_q;
   logic rise;
   logic [15:0] pos;
   // Cycles since the last frame start, zero until one was seen
   assign rise = o_frame_pulse_122ns & ~fp_q;
   always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
         fp_q <= 1'b1;
         pos <= 16'h0000;
      end else begin
         fp_q <= o_frame_pulse_122ns;
         if (rise)
            pos <= 16'h0001;
         else if (pos != 16'h0000 && pos != 16'hFFFF)
            pos <= pos + 16'h0001;
      end
   end
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_rst);
   a_state_on_frame: assert property (
      $changed({o_normal, o_holdover, o_freerun}) |-> rise)
      else $error("mode indicators changed away from a frame start");
   a_one_mode_shown: assert property (
      $onehot({o_normal, o_holdover, o_freerun}))
      else $error("mode indicators not one-hot");
   a_pulses_aligned: assert property (
      rise |-> $fell(o_frame_pulse_31ns_n) && $fell(o_frame_pulse_61ns_n)
      && $fell(o_frame_pulse_244ns_n) && $rose(o_receive_sync_pulse)
      && $rose(o_transmit_sync_pulse))
      else $error("frame pulses do not start together");
   a_width_31ns: assert property (
      pos != 16'h0000 && pos < 16'h0100 |-> o_frame_pulse_31ns_n == (pos >= 16'(FP31_CYC)))
      else $error("31 ns pulse width wrong");
   a_width_61ns: assert property (
      pos != 16'h0000 && pos < 16'h0100 |-> o_frame_pulse_61ns_n == (pos >= 16'(FP61_CYC)))
      else $error("61 ns pulse width wrong");
   a_width_122ns: assert property (
      pos != 16'h0000 && pos < 16'h0100 |-> o_frame_pulse_122ns == (pos < 16'(FP122_CYC)))
      else $error("122 ns pulse width wrong");
   a_width_244ns: assert property (
      pos != 16'h0000 && pos < 16'h0100 |-> o_frame_pulse_244ns_n == (pos >= 16'(FP244_CYC)))
      else $error("244 ns pulse width wrong");
   a_width_sync: assert property (
      pos != 16'h0000 && pos < 16'h0100 |-> o_receive_sync_pulse == (pos < 16'(SYNC_CYC))
      && o_transmit_sync_pulse == (pos < 16'(SYNC_CYC)))
      else $error("sync pulse width wrong");
   a_frame_nominal: assert property (
      rise && $past(o_freerun || o_holdover) |-> pos == 16'h0000 || pos == 16'(FRAME_CYCLES))
      else $error("free or held frame length not nominal");
   a_reset_idle_high: assert property (disable iff (1'b0)
      i_rst |=> o_freerun && &{o_clk_32m768_out, o_clk_16m384_out, o_clk_8m192_out,
      o_clk_4m096_out, o_clk_2m048_out, o_clk_3m088_out, o_clk_1m544_out, o_clk_6m312_out,
      o_frame_pulse_31ns_n, o_frame_pulse_61ns_n, o_frame_pulse_122ns,
      o_frame_pulse_244ns_n, o_receive_sync_pulse, o_transmit_sync_pulse})
      else $error("outputs not held high in reset");
   // Rising edges of each output clock over one free or held frame
   logic [NCO_COUNT-1:0] ck;
   assign ck = {o_clk_6m312_out, o_clk_1m544_out, o_clk_3m088_out, o_clk_2m048_out,
      o_clk_4m096_out, o_clk_8m192_out, o_clk_16m384_out, o_clk_32m768_out};
   genvar g;
   for (g = 0; g < NCO_COUNT; g++) begin : g_ck
      logic ck_q;
      logic [12:0] n;
      always_ff @(posedge i_core_clk) begin
         ck_q <= ck[g];
         if (i_rst)
            n <= 13'h0000;
         else if (rise)
            n <= 13'h0001;
         else if (ck[g] && !ck_q)
            n <= n + 13'h0001;
      end
      a_clock_count: assert property (
         rise && pos != 16'h0000 && $past(o_freerun || o_holdover)
         |-> n == 13'(NCO_KHZ[g] * FRAME_US / 1000))
         else $error("clock edge count per frame wrong");
   end
endmodule

/* tb/ref_source_model.sv */
// Reference pin source of the timing network side
`timescale 1ns/1ps
module ref_source_model (
   input wire logic i_core_clk,
   input wire logic i_enable,
   input wire logic [7:0] i_period,
   output logic o_ref
);
   logic [7:0] cnt = 8'h00;
   initial o_ref = 1'b1;
   // A lost source leaves the pin at its pull-up level
   always @(posedge i_core_clk) begin
      if (!i_enable) begin
         cnt <= 8'h00;
         o_ref <= 1'b1;
      end else begin
         cnt <= (cnt >= i_period - 8'h01) ? 8'h00 : cnt + 8'h01;
         o_ref <= (cnt < (i_period >> 1));
      end
   end
endmodule

/* tb/testbench.sv */
// Self-checking bench for the mode state controller
`timescale 1ns/1ps
module testbench;
   import dpll_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] msel = 2'h2;
   logic corr = 1'b0;
   logic fast = 1'b0;
   logic ref_on = 1'b0;
   logic ref_pin;
   logic [7:0] ref_per = 8'h7A;
   logic [3:0] addr = 4'h0;
   logic rd_req = 1'b0;
   logic wr_req = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] be = 4'hF;
   logic [31:0] rdata;
   logic wait_req;
   logic [7:0] clks;
   logic [5:0] pulses;
   logic nrm, hld, frr, lck;
   logic [31:0] q;
   logic [31:0] d;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   initial forever #2 clk = ~clk;
   ref_source_model u_ref (.i_core_clk(clk), .i_enable(ref_on), .i_period(ref_per),
      .o_ref(ref_pin));
   dpll_mode_state_control u_dut (.i_core_clk(clk), .i_rst(rst), .i_ref(ref_pin),
      .i_freq_select(2'h3), .i_mode_select_hi(msel[1]), .i_mode_select_lo(msel[0]),
      .i_phase_error_corr_enable(corr), .i_fast_lock_request(fast), .i_tie_clear_n(1'b1),
      .i_avs_address(addr), .i_avs_read(rd_req), .i_avs_write(wr_req),
      .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wait_req), .o_clk_32m768_out(clks[0]), .o_clk_16m384_out(clks[1]),
      .o_clk_8m192_out(clks[2]), .o_clk_4m096_out(clks[3]), .o_clk_2m048_out(clks[4]),
      .o_clk_3m088_out(clks[5]), .o_clk_1m544_out(clks[6]), .o_clk_6m312_out(clks[7]),
      .o_frame_pulse_31ns_n(pulses[0]), .o_frame_pulse_61ns_n(pulses[1]),
      .o_frame_pulse_122ns(pulses[2]), .o_frame_pulse_244ns_n(pulses[3]),
      .o_receive_sync_pulse(pulses[4]), .o_transmit_sync_pulse(pulses[5]),
      .o_normal(nrm), .o_holdover(hld), .o_freerun(frr), .o_lock(lck));
   task automatic stop_test();
      $display("compared %0d values, %0d mismatches", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 100000) begin
         err_count++;
         stop_test();
      end
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] v,
         input logic [3:0] en, output logic [31:0] r);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      be <= en;
      wr_req <= wr;
      rd_req <= !wr;
      do
         @(posedge clk);
      while (wait_req !== 1'b0);
      r = rdata;
      wr_req <= 1'b0;
      rd_req <= 1'b0;
   endtask
   // Expected status fields without the lock bit
   function automatic logic [31:0] exp_st(input dpll_state_t s, input logic rv,
         input logic c, input logic [1:0] m);
      exp_st = {26'h0, m, c, rv, 2'(s)};
   endfunction
   task automatic status_is(input logic [31:0] e);
      bus(1'b0, REG_STATUS, 32'h0, 4'hF, q);
      check({26'h0, q[6:3], q[1:0]}, e);
   endtask
   task automatic wait_frame();
      do
         @(negedge clk);
      while (pulses[2] !== 1'b0);
      do
         @(negedge clk);
      while (pulses[2] !== 1'b1);
   endtask
   initial begin
      void'($urandom(16));
      ref_per <= 8'h79 + 8'($urandom % 3);
      repeat (16) @(posedge clk);
      check({30'h0, &{clks, pulses}, frr}, 32'h3);
      rst <= 1'b0;
      // Let the mode pins pass the synchroniser before the first status read
      repeat (4) @(posedge clk);
      status_is(exp_st(ST_FREERUN, 1'b0, 1'b0, 2'h2));
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, 4'hC + 4'($urandom % 4), $urandom, 4'hF, q);
         bus(1'b0, 4'hC + 4'($urandom % 4), 32'h0, 4'hF, q);
         check(q, 32'h0);
      end
      d = $urandom;
      bus(1'b1, REG_CTRL, d, 4'h1, q);
      bus(1'b1, REG_CTRL, ~d, 4'h0, q);
      bus(1'b0, REG_CTRL, 32'h0, 4'hF, q);
      check(q, {31'h0, d[0]});
      msel <= MODE_NORMAL;
      corr <= 1'b1;
      fast <= 1'($urandom);
      ref_on <= 1'b1;
      wait_frame();
      check({29'h0, nrm, hld, frr}, 32'h4);
      status_is(exp_st(ST_NORMAL, 1'b1, 1'b0, 2'h0));
      ref_on <= 1'b0;
      wait_frame();
      check({29'h0, nrm, hld, frr}, 32'h2);
      status_is(exp_st(ST_AUTO_HOLD, 1'b0, 1'b0, 2'h0));
      ref_on <= 1'b1;
      wait_frame();
      check({29'h0, nrm, hld, frr}, 32'h4);
      status_is(exp_st(ST_NORMAL, 1'b1, 1'b1, 2'h0));
      stop_test();
   end
endmodule
bind dpll_mode_state_control dpll_mode_assertions u_chk (.i_core_clk(i_core_clk),
   .i_rst(i_rst), .o_clk_32m768_out(o_clk_32m768_out), .o_clk_16m384_out(o_clk_16m384_out),
   .o_clk_8m192_out(o_clk_8m192_out), .o_clk_4m096_out(o_clk_4m096_out),
   .o_clk_2m048_out(o_clk_2m048_out), .o_clk_3m088_out(o_clk_3m088_out),
   .o_clk_1m544_out(o_clk_1m544_out), .o_clk_6m312_out(o_clk_6m312_out),
   .o_frame_pulse_31ns_n(o_frame_pulse_31ns_n), .o_frame_pulse_61ns_n(o_frame_pulse_61ns_n),
   .o_frame_pulse_122ns(o_frame_pulse_122ns), .o_frame_pulse_244ns_n(o_frame_pulse_244ns_n),
   .o_receive_sync_pulse(o_receive_sync_pulse), .o_transmit_sync_pulse(o_transmit_sync_pulse),
   .o_normal(o_normal), .o_holdover(o_holdover), .o_freerun(o_freerun));
